// ### rtl/vco_autocal_fsm.sv
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: autocal enabled means device owns cal bit
// RULE2: start sets calibration-mode bit to preset tune
// RULE3: binary search core and subband at preset
// RULE4: band found clears calibration-mode bit
// RULE5: band data via serial port, address kept
// RULE6: host programs subsystem address beforehand
// RULE7: auto relock on unlock, only once
// RULE8: frequency change starts calibration automatically
// RULE9: rewriting same value reruns calibration
// RULE10: measure lasts pd period times two^n
// RULE11: expected count per pd cycle floor N
// RULE12: N from integer plus fraction over 2^24
// RULE13: calib clock is reference over 2^m; code divides by 1, 4, 16 or 32 for m of 0 to 3
// RULE14: host keeps calib clock under 50 MHz
// RULE15: host should set clock divide to two
// RULE16: wait 20 times k+1 before measuring
// RULE17: wait, measure, 20-cycle transfer, eight times
// RULE18: host should use highest resolution
// RULE19: accept step whose range contains target
// RULE20: no core preselect while autocal enabled
// RULE21: host may write band settings directly
// RULE22: selected band readable after calibration
// RULE23: keep trial bit if count below expected
module vco_autocal_fsm #(
	parameter int CNT_W = 32
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	input  wire logic        ref_tick,
	input  wire logic        vco_tick,
	input  wire logic        lock_detect,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             cal_mode_r,
	output logic [15:0]      internal_vco_serial_port_word_r,
	output logic             internal_vco_serial_port_load_r,
	output logic             freq_load_r
);

	////////////////////////////////////////////////////////////////////////
	// input synchronisers: three stages, a change counts when 2 and 3 agree

	logic [2:0] ref_sync_r;
	logic [2:0] vco_sync_r;
	logic [2:0] lock_sync_r;
	logic       ref_lvl_r;
	logic       vco_lvl_r;
	logic       lock_lvl_r;
	logic       ref_prev_r;
	logic       vco_prev_r;
	logic       ref_edge;
	logic       vco_edge;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_sync_r  <= 3'h0;
			vco_sync_r  <= 3'h0;
			lock_sync_r <= 3'h0;
			ref_lvl_r   <= 1'b0;
			vco_lvl_r   <= 1'b0;
			lock_lvl_r  <= 1'b0;
			ref_prev_r  <= 1'b0;
			vco_prev_r  <= 1'b0;
		end else if (clk_en) begin
			ref_sync_r  <= {ref_sync_r[1:0], ref_tick};
			vco_sync_r  <= {vco_sync_r[1:0], vco_tick};
			lock_sync_r <= {lock_sync_r[1:0], lock_detect};
			if (ref_sync_r[1] == ref_sync_r[2])
				ref_lvl_r <= ref_sync_r[2];
			if (vco_sync_r[1] == vco_sync_r[2])
				vco_lvl_r <= vco_sync_r[2];
			if (lock_sync_r[1] == lock_sync_r[2])
				lock_lvl_r <= lock_sync_r[2];
			ref_prev_r <= ref_lvl_r;
			vco_prev_r <= vco_lvl_r;
		end
	end

	assign ref_edge = ref_lvl_r & ~ref_prev_r;
	// vco_tick is the prescaled vco, slow enough to be sampled here
	assign vco_edge = vco_lvl_r & ~vco_prev_r;

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [31:0] ctrl_r;
	logic [31:0] autocal_r;
	logic [31:0] int_div_r;
	logic [31:0] frac_div_r;
	logic [15:0] internal_vco_serial_port_reg_r;
	logic [7:0]  band_r;
	logic        busy_r;
	logic        relock_used_r;
	logic        freq_req_r;

	logic [31:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        aw_have_r;
	logic        w_have_r;
	logic        wr_go;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		return res;
	endfunction : merge

	function automatic logic known(input logic [7:0] a);
		return (a == vco_autocal_pkg::OFF_CTRL) ||
			(a == vco_autocal_pkg::OFF_AUTOCAL) ||
			(a == vco_autocal_pkg::OFF_INT_DIV) ||
			(a == vco_autocal_pkg::OFF_FRAC_DIV) ||
			(a == vco_autocal_pkg::OFF_INTERNAL_VCO_SERIAL_PORT) ||
			(a == vco_autocal_pkg::OFF_STATUS);
	endfunction : known

	assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			awaddr_r      <= 32'h0;
			wdata_r       <= 32'h0;
			wstrb_r       <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= vco_autocal_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r      <= s_axi_awaddr;
				aw_have_r     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				w_have_r     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (known(awaddr_r[7:0]) &&
					awaddr_r[31:8] == 24'h0) ?
					vco_autocal_pkg::RESP_OKAY :
					vco_autocal_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	logic wr_ok;
	assign wr_ok = wr_go && awaddr_r[31:8] == 24'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r     <= 32'h0;
			autocal_r  <= vco_autocal_pkg::AUTOCAL_RST;
			int_div_r  <= vco_autocal_pkg::INT_RST;
			frac_div_r <= 32'h0;
		end else if (clk_en && wr_ok) begin
			if (awaddr_r[7:0] == vco_autocal_pkg::OFF_CTRL)
				ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
			else if (awaddr_r[7:0] == vco_autocal_pkg::OFF_AUTOCAL)
				autocal_r <= merge(autocal_r, wdata_r, wstrb_r);
			else if (awaddr_r[7:0] == vco_autocal_pkg::OFF_INT_DIV)
				int_div_r <= merge(int_div_r, wdata_r, wstrb_r);
			else if (awaddr_r[7:0] == vco_autocal_pkg::OFF_FRAC_DIV)
				// top byte reads as zero: the fraction is 24 bits
				frac_div_r <= merge(frac_div_r, wdata_r, wstrb_r) &
					32'h00FF_FFFF;
		end
	end

	logic autocal_on;
	logic div_write;
	logic host_internal_vco_serial_port_write;
	assign autocal_on = ~autocal_r[vco_autocal_pkg::DISABLE_BIT]; // RULE1
	// any write to the divider registers is a frequency change,
	// even with an unchanged value
	assign div_write = wr_ok &&
		(awaddr_r[7:0] == vco_autocal_pkg::OFF_INT_DIV ||
		awaddr_r[7:0] == vco_autocal_pkg::OFF_FRAC_DIV); // RULE9
	assign host_internal_vco_serial_port_write = wr_ok &&
		awaddr_r[7:0] == vco_autocal_pkg::OFF_INTERNAL_VCO_SERIAL_PORT;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= vco_autocal_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= vco_autocal_pkg::RESP_OKAY;
				if (s_axi_araddr[31:8] != 24'h0) begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= vco_autocal_pkg::RESP_SLVERR;
				end else if (s_axi_araddr[7:0] == vco_autocal_pkg::OFF_CTRL)
					s_axi_rdata <= ctrl_r;
				else if (s_axi_araddr[7:0] == vco_autocal_pkg::OFF_AUTOCAL)
					s_axi_rdata <= autocal_r;
				else if (s_axi_araddr[7:0] == vco_autocal_pkg::OFF_INT_DIV)
					s_axi_rdata <= int_div_r;
				else if (s_axi_araddr[7:0] == vco_autocal_pkg::OFF_FRAC_DIV)
					s_axi_rdata <= frac_div_r;
				else if (s_axi_araddr[7:0] == vco_autocal_pkg::OFF_INTERNAL_VCO_SERIAL_PORT)
					s_axi_rdata <= {16'h0, internal_vco_serial_port_reg_r};
				else if (s_axi_araddr[7:0] == vco_autocal_pkg::OFF_STATUS)
					s_axi_rdata <= {22'h0, relock_used_r, busy_r,
						band_r}; // RULE22
				else begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= vco_autocal_pkg::RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// calib clock: one tick per 1, 4, 16 or 32 reference edges for m of 0 to 3

	logic [4:0] div_cnt_r;
	logic [4:0] div_top;
	logic       cal_tick;
	always_comb begin
		case (autocal_r[vco_autocal_pkg::CLKDIV_LSB +: 2])
			2'h0:    div_top = 5'h00;
			2'h1:    div_top = 5'h03;
			2'h2:    div_top = 5'h0F;
			default: div_top = 5'h1F;
		endcase
	end
	assign cal_tick = ref_edge && div_cnt_r == div_top; // RULE13

	always_ff @(posedge aclk) begin
		if (!aresetn)
			div_cnt_r <= 5'h00;
		else if (clk_en && ref_edge)
			div_cnt_r <= (div_cnt_r >= div_top) ? 5'h00 : div_cnt_r + 5'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// search engine

	vco_autocal_pkg::cal_state_t state_r;
	logic [11:0]      step_cnt_r;
	logic [8:0]       pd_cnt_r;
	logic [CNT_W-1:0] vco_cnt_r;
	logic [3:0]       bit_idx_r;
	logic [7:0]       trial_r;
	logic [CNT_W-1:0] expect_cnt;
	logic [8:0]       pd_total;
	logic [11:0]      wait_total;
	logic [55:0]      n_scaled;

	// N scaled by 2^24 then by 2^n, truncated: floor(N * 2^n)
	assign n_scaled = ({24'h0, int_div_r} << vco_autocal_pkg::FRAC_BITS) +
		{32'h0, frac_div_r[23:0]}; // RULE12
	assign expect_cnt = CNT_W'((n_scaled << autocal_r[2:0]) >>
		vco_autocal_pkg::FRAC_BITS); // RULE11
	assign pd_total = 9'h001 << autocal_r[2:0]; // RULE10
	assign wait_total = 12'(vco_autocal_pkg::WAIT_UNIT) *
		(12'(autocal_r[vco_autocal_pkg::WAIT_LSB +: 7]) + 12'h001); // RULE16

	logic lock_fall;
	logic lock_prev_r;
	assign lock_fall = lock_prev_r & ~lock_lvl_r;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lock_prev_r <= 1'b0;
		else if (clk_en)
			lock_prev_r <= lock_lvl_r;
	end

	// a request arriving mid-search is held until the search ends
	always_ff @(posedge aclk) begin
		if (!aresetn)
			freq_req_r <= 1'b0;
		else if (clk_en) begin
			if (div_write && autocal_on)
				freq_req_r <= 1'b1; // RULE8
			else if (state_r == vco_autocal_pkg::ST_IDLE && cal_tick)
				freq_req_r <= 1'b0;
		end
	end

	// lock_fall lasts one cycle and seldom meets a calib tick,
	// so the relock request is held until the next tick
	logic relock_go;
	logic relock_req_r;
	assign relock_go = ctrl_r[vco_autocal_pkg::RELOCK_BIT] && lock_fall &&
		!relock_used_r && autocal_on &&
		state_r == vco_autocal_pkg::ST_IDLE; // RULE7

	always_ff @(posedge aclk) begin
		if (!aresetn)
			relock_used_r <= 1'b0;
		else if (clk_en) begin
			if (relock_go)
				relock_used_r <= 1'b1; // RULE7
			else if (div_write)
				relock_used_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			relock_req_r <= 1'b0;
		else if (clk_en) begin
			if (relock_go)
				relock_req_r <= 1'b1;
			else if (state_r == vco_autocal_pkg::ST_IDLE && cal_tick)
				relock_req_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r     <= vco_autocal_pkg::ST_IDLE;
			busy_r      <= 1'b0;
			cal_mode_r  <= 1'b0;
			step_cnt_r  <= 12'h000;
			pd_cnt_r    <= 9'h000;
			vco_cnt_r   <= '0;
			bit_idx_r   <= 4'h0;
			trial_r     <= 8'h00;
			band_r      <= 8'h00;
			freq_load_r <= 1'b0;
		end else if (clk_en) begin
			freq_load_r <= 1'b0;
			if (div_write && !autocal_on)
				freq_load_r <= 1'b1;
			if (state_r == vco_autocal_pkg::ST_MEASURE) begin
				if (vco_edge)
					vco_cnt_r <= vco_cnt_r + CNT_W'(1);
				if (ref_edge)
					pd_cnt_r <= pd_cnt_r + 9'h001;
			end
			case (state_r)
				vco_autocal_pkg::ST_IDLE: if (cal_tick &&
						(freq_req_r || relock_req_r)) begin
					busy_r     <= 1'b1;
					cal_mode_r <= 1'b1; // RULE2
					// search always starts from the top core bit
					trial_r    <= 8'h80; // RULE20
					bit_idx_r  <= 4'h7;
					// a stale count would skip the first trial bit
					pd_cnt_r   <= 9'h000;
					step_cnt_r <= 12'h000;
					state_r    <= vco_autocal_pkg::ST_CALON;
				end
				vco_autocal_pkg::ST_CALON: if (cal_tick) begin
					state_r <= vco_autocal_pkg::ST_XFER;
				end
				vco_autocal_pkg::ST_WAIT: if (cal_tick) begin
					step_cnt_r <= step_cnt_r + 12'h001;
					if (step_cnt_r + 12'h001 >= wait_total) begin
						pd_cnt_r  <= 9'h000;
						vco_cnt_r <= '0;
						state_r   <= vco_autocal_pkg::ST_MEASURE;
					end
				end
				vco_autocal_pkg::ST_MEASURE:
					if (ref_edge && pd_cnt_r + 9'h001 >= pd_total) begin
					// slow trial keeps its bit set to raise frequency
					if (vco_cnt_r >= expect_cnt) // RULE23
						trial_r[bit_idx_r[2:0]] <= 1'b0; // RULE3
					if (bit_idx_r != 4'h0)
						trial_r[bit_idx_r[2:0] - 3'h1] <= 1'b1;
					step_cnt_r <= 12'h000;
					state_r    <= vco_autocal_pkg::ST_XFER; // RULE17
				end
				vco_autocal_pkg::ST_XFER: if (cal_tick) begin
					step_cnt_r <= step_cnt_r + 12'h001;
					if (step_cnt_r + 12'h001 >= 12'(vco_autocal_pkg::XFER_CYCLES))
						begin
						step_cnt_r <= 12'h000;
						if (pd_cnt_r != 9'h000 && bit_idx_r == 4'h0) begin
							band_r  <= trial_r; // RULE19
							state_r <= vco_autocal_pkg::ST_CALOFF;
						end else begin
							if (pd_cnt_r != 9'h000)
								bit_idx_r <= bit_idx_r - 4'h1;
							pd_cnt_r <= 9'h000;
							state_r  <= vco_autocal_pkg::ST_WAIT;
						end
					end
				end
				vco_autocal_pkg::ST_CALOFF: if (cal_tick) begin
					cal_mode_r  <= 1'b0; // RULE4
					busy_r      <= 1'b0;
					freq_load_r <= 1'b1;
					state_r     <= vco_autocal_pkg::ST_IDLE;
				end
				default: state_r <= vco_autocal_pkg::ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// vco serial port word: address field belongs to the host

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			internal_vco_serial_port_reg_r  <= 16'h0000;
			internal_vco_serial_port_word_r <= 16'h0000;
			internal_vco_serial_port_load_r <= 1'b0;
		end else if (clk_en) begin
			internal_vco_serial_port_load_r <= 1'b0;
			if (host_internal_vco_serial_port_write && !busy_r) begin
				internal_vco_serial_port_reg_r  <= wdata_r[15:0]; // RULE21
				internal_vco_serial_port_word_r <= wdata_r[15:0];
				internal_vco_serial_port_load_r <= 1'b1;
			end else if (busy_r && state_r == vco_autocal_pkg::ST_XFER &&
				cal_tick && step_cnt_r == 12'h000) begin
				internal_vco_serial_port_reg_r[vco_autocal_pkg::INTERNAL_VCO_SERIAL_PORT_DATA_LSB +:
					vco_autocal_pkg::INTERNAL_VCO_SERIAL_PORT_DATA_W] <= {1'b0, trial_r};
				internal_vco_serial_port_word_r <= {{1'b0, trial_r},
					internal_vco_serial_port_reg_r[vco_autocal_pkg::INTERNAL_VCO_SERIAL_PORT_ADDR_LSB +:
					vco_autocal_pkg::INTERNAL_VCO_SERIAL_PORT_ADDR_W]}; // RULE5
				internal_vco_serial_port_load_r <= 1'b1;
			end
		end
	end

endmodule : vco_autocal_fsm

// ### rtl/vco_autocal_pkg.sv
package vco_autocal_pkg;

	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_AUTOCAL   = 8'h04;
	localparam logic [7:0] OFF_INT_DIV   = 8'h08;
	localparam logic [7:0] OFF_FRAC_DIV  = 8'h0C;
	localparam logic [7:0] OFF_INTERNAL_VCO_SERIAL_PORT      = 8'h10;
	localparam logic [7:0] OFF_STATUS    = 8'h14;

	// autocal config field positions
	localparam int RES_LSB     = 0;
	localparam int WAIT_LSB    = 3;
	localparam int CLKDIV_LSB  = 13;
	localparam int DISABLE_BIT = 11;
	// ctrl register bit
	localparam int RELOCK_BIT  = 13;

	// vco serial port fields
	localparam int INTERNAL_VCO_SERIAL_PORT_ADDR_LSB = 0;
	localparam int INTERNAL_VCO_SERIAL_PORT_ADDR_W   = 7;
	localparam int INTERNAL_VCO_SERIAL_PORT_DATA_LSB = 7;
	localparam int INTERNAL_VCO_SERIAL_PORT_DATA_W   = 9;
	localparam int CALMODE_BIT   = 7;

	// reset values
	localparam logic [31:0] AUTOCAL_RST = 32'h0000_400F;
	localparam logic [31:0] INT_RST     = 32'h0000_0010;

	// timing in calib clock cycles, then search and fraction bit counts
	localparam int WAIT_UNIT    = 20;
	localparam int XFER_CYCLES  = 20;
	localparam int SEARCH_BITS  = 8;
	localparam int FRAC_BITS    = 24;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_CALON   = 3'b001,
		ST_WAIT    = 3'b010,
		ST_MEASURE = 3'b011,
		ST_XFER    = 3'b100,
		ST_CALOFF  = 3'b101
	} cal_state_t;

endpackage : vco_autocal_pkg

// ### dv/vco_far_model.sv
`timescale 1ns/10ps
module vco_far_model (
	input  wire logic aclk,
	input  wire logic unlock,
	output logic      ref_tick,
	output logic      vco_tick,
	output logic      lock_detect
);
	logic [1:0] rc = 2'h0;
	logic [3:0] vc = 4'h0;
	initial ref_tick = 1'b0;
	initial vco_tick = 1'b0;
	////////////////////////////////////////////////////////////////////
	// pd clock, period of eight aclk cycles
	always @(posedge aclk) begin
		rc <= rc + 2'h1;
		if (rc == 2'h3)
			ref_tick <= ~ref_tick;
	end
	// slow oscillator: kept under aclk/8 so no edge is lost in sync
	always @(posedge aclk) begin
		vc <= (vc == 4'hB) ? 4'h0 : vc + 4'h1;
		if (vc == 4'hB)
			vco_tick <= ~vco_tick;
	end
	assign lock_detect = !unlock;
endmodule : vco_far_model

// ### dv/vco_autocal_properties.sv
`timescale 1ns/10ps
module vco_autocal_properties (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       cal_mode_r,
	input wire logic       internal_vco_serial_port_load_r,
	input wire logic       freq_load_r
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	////////////////////////////////////////////////////////////////////
	reset_idle_a: assert property ($rose(aresetn) |->
		!cal_mode_r && !s_axi_bvalid && s_axi_awready)
		else $error("outputs not idle after reset");
	write_resp_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (b_wait |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	resp_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address ready during response");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |->
		##[1:2] s_axi_rvalid) else $error("read response late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed");
	first_xfer_a: assert property ($rose(cal_mode_r) |->
		##[1:600] internal_vco_serial_port_load_r) else $error("no trial transfer");
	load_gap_a: assert property (cal_mode_r && internal_vco_serial_port_load_r |=>
		!internal_vco_serial_port_load_r [*8]) else $error("serial loads too close");
	cal_end_a: assert property ($fell(cal_mode_r) |->
		##[0:4] freq_load_r) else $error("no frequency load");
endmodule : vco_autocal_properties
bind vco_autocal_fsm vco_autocal_properties i_vco_autocal_properties (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .cal_mode_r(cal_mode_r),
	.internal_vco_serial_port_load_r(internal_vco_serial_port_load_r), .freq_load_r(freq_load_r));

// ### dv/vco_autocal_fsm_tb.sv
`timescale 1ns/10ps
module vco_autocal_fsm_tb;
	typedef struct packed {logic [2:0] k; logic [31:0] d, m;} exp_t;
	logic        aclk = 0, aresetn = 0, clk_en = 1, unlock = 0;
	logic        ref_tick, vco_tick, lock_detect;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic        rready = 0, awready, wready, bvalid, arready, rvalid;
	logic        cal_mode, vload, fload;
	logic [1:0]  bresp, rresp;
	logic [15:0] vword, lfsr = 16'h003D, v;
	int          n_fail = 0, compares = 0, loads, fls, cyc = 0, last, gap;
	int          held;
	exp_t        q[$];
	initial forever #4 aclk = ~aclk;
	vco_far_model i_vco_far_model (.aclk(aclk), .unlock(unlock),
		.ref_tick(ref_tick), .vco_tick(vco_tick), .lock_detect(lock_detect));
	vco_autocal_fsm i_vco_autocal_fsm (
		.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.ref_tick(ref_tick), .vco_tick(vco_tick), .lock_detect(lock_detect),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cal_mode_r(cal_mode), .internal_vco_serial_port_word_r(vword), .internal_vco_serial_port_load_r(vload),
		.freq_load_r(fload));
	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr_next
	task automatic chk(input logic ok, input string s);
		compares++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t %s", $time, s);
		end
	endtask : chk
	task automatic final_report();
		$display("counts: %0d compares, %0d fails", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////
	// expected answers queue up here; the monitor below drains them
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		bit aw, w;
		q.push_back({1'b0, r, 32'h0, 32'h0});
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		aw = 0;
		w = 0;
		do begin
			@(posedge aclk);
			if (awready) aw = 1;
			if (wready) w = 1;
			if (aw) awvalid <= 0;
			if (w) wvalid <= 0;
		end while (!(aw && w));
		// a late bready exercises the held response
		repeat (cyc % 4) @(posedge aclk);
		bready <= 1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, m,
		input logic [1:0] r);
		q.push_back({1'b1, r, d, m});
		araddr <= {24'h0, a};
		arvalid <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		repeat (cyc % 4) @(posedge aclk);
		rready <= 1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 0;
		@(posedge aclk);
	endtask : rd
	always @(posedge aclk) begin
		exp_t e;
		cyc++;
		if (fload) fls++;
		if ((bvalid && bready) || (rvalid && rready)) begin
			e = q.pop_front();
			if (rvalid) chk(((rdata ^ e.d) & e.m) == 0 && rresp === e.k[1:0],
				"read mismatch");
			else chk(bresp === e.k[1:0] && !e.k[2], "write resp mismatch");
		end
		if (vload) begin
			loads++;
			chk(vword[6:0] === 7'h55, "serial address altered");
			if (loads > 1 && cal_mode === 1'b1)
				chk(cyc - last >= gap - 24 && cyc - last <= gap + 24,
					"step spacing");
			last = cyc;
		end
	end
	task automatic expect_cal(input bit yes, input int b);
		int t;
		t = 0;
		loads = 0;
		while (cal_mode !== 1'b1 && t < b) begin
			@(posedge aclk);
			t++;
		end
		chk((cal_mode === 1'b1) == yes, "calibration start");
		t = 0;
		while (cal_mode !== 1'b0 && t < 9000) begin
			@(posedge aclk);
			t++;
		end
	endtask : expect_cal
	task automatic cal_run(input logic [7:0] a, d, band);
		wr(a, {24'h0, d}, vco_autocal_pkg::RESP_OKAY);
		expect_cal(1, 200);
		chk(loads === 9, "load count");
		rd(vco_autocal_pkg::OFF_STATUS, {24'h0, band}, 32'h1FF,
			vco_autocal_pkg::RESP_OKAY);
	endtask : cal_run
	initial begin
		#480000;
		n_fail++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rd(vco_autocal_pkg::OFF_AUTOCAL, vco_autocal_pkg::AUTOCAL_RST,
			32'hFFFFFFFF, vco_autocal_pkg::RESP_OKAY);
		rd(vco_autocal_pkg::OFF_INT_DIV, vco_autocal_pkg::INT_RST,
			32'hFFFFFFFF, vco_autocal_pkg::RESP_OKAY);
		rd(8'h40, 32'h0, 32'hFFFFFFFF, vco_autocal_pkg::RESP_SLVERR);
		wr(8'h40, 32'h0, vco_autocal_pkg::RESP_SLVERR);
		$display("test registers done");
		lfsr = lfsr_next(lfsr);
		v = {lfsr[8:0], 7'h55};
		wr(vco_autocal_pkg::OFF_INTERNAL_VCO_SERIAL_PORT, {16'h0, v}, 2'h0);
		while (vload !== 1'b1 && cyc < 2000) @(posedge aclk);
		chk(vword === v, "manual serial word");
		$display("test manual band done");
		wr(vco_autocal_pkg::OFF_AUTOCAL, 32'h8, 2'h0);
		gap = (20 + 40 + 1) * 8;
		lfsr = lfsr_next(lfsr);
		cal_run(vco_autocal_pkg::OFF_FRAC_DIV, lfsr[7:0], 8'hFF);
		rd(vco_autocal_pkg::OFF_FRAC_DIV, {24'h0, lfsr[7:0]}, 32'hFFFFFF,
			2'h0);
		cal_run(vco_autocal_pkg::OFF_INT_DIV, 8'h10, 8'hFF);
		cal_run(vco_autocal_pkg::OFF_INT_DIV, 8'h10, 8'hFF);
		$display("test search kept done");
		wr(vco_autocal_pkg::OFF_AUTOCAL, 32'h2, 2'h0);
		gap = (20 + 20 + 4) * 8;
		cal_run(vco_autocal_pkg::OFF_FRAC_DIV, 8'h0, 8'hFF);
		cal_run(vco_autocal_pkg::OFF_INT_DIV, 8'h0, 8'h00);
		$display("test search cleared done");
		wr(vco_autocal_pkg::OFF_AUTOCAL, 32'h808, 2'h0);
		fls = 0;
		wr(vco_autocal_pkg::OFF_INT_DIV, 32'h10, 2'h0);
		expect_cal(0, 600);
		chk(fls === 1, "direct frequency load");
		$display("test disabled done");
		wr(vco_autocal_pkg::OFF_AUTOCAL, 32'h8, 2'h0);
		gap = (20 + 40 + 1) * 8;
		wr(vco_autocal_pkg::OFF_CTRL, 32'h2000, 2'h0);
		cal_run(vco_autocal_pkg::OFF_INT_DIV, 8'h10, 8'hFF);
		unlock <= 1;
		expect_cal(1, 200);
		chk(loads === 9, "relock load count");
		unlock <= 0;
		repeat (20) @(posedge aclk);
		unlock <= 1;
		expect_cal(0, 1500);
		unlock <= 0;
		$display("test relock done");
		wr(vco_autocal_pkg::OFF_INT_DIV, 32'h10, 2'h0);
		while (cal_mode !== 1'b1 && cyc < 60000) @(posedge aclk);
		held = loads;
		clk_en <= 0;
		repeat (300) @(posedge aclk);
		chk(cal_mode === 1'b1 && loads === held, "freeze");
		clk_en <= 1;
		expect_cal(1, 200);
		chk(loads === 9, "load count after freeze");
		$display("test freeze done");
		final_report();
	end
endmodule : vco_autocal_fsm_tb
